// ===== verification/cfs_sense_model.sv
// sense network model: turns drive pulses into current comparator levels
// assumes gate is registered on the rising edge of clk
`timescale 1ns/1ps

module cfs_sense_model #(
  parameter int LIM_AT  = 10,
  parameter int STOP_AT = 5
) (
  // clock and drive
  input  wire logic       clk,
  input  wire logic       gate,
  input  wire logic [1:0] mode,
  // comparator levels
  output logic            cs_limit,
  output logic            cs_stop
);
  // mode 0 limit reached, 1 limit never reached, 2 surge above the stop level
  int on_cyc = 0;

  always @(posedge clk) begin
    on_cyc <= gate ? on_cyc + 1 : 0;
  end
  // sense voltage collapses as soon as the switch opens
  assign cs_limit = gate && mode != 2'h1 && on_cyc >= LIM_AT;
  assign cs_stop  = gate && mode == 2'h2 && on_cyc >= STOP_AT;
endmodule

// ===== verification/cfs_supervisor_bench.sv
// self-checking bench of the converter fault supervisor
// assumes the package and the sense model are compiled before this file
`timescale 1ns/1ps

module cfs_supervisor_bench;
  import cfs_pkg::*;
  // ==========================================
  // reduced counts and signals
  localparam int PER   = 32;
  localparam int OVL   = 50;
  localparam int REC   = 60;
  localparam int TBL   = 10;
  localparam int BOOT  = 5;
  localparam int MAXON = PER * 48 / 100;

  logic       ref_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic       ovl, cs_lim, cs_stp, cs_open, f_hi, f_lo, s_ov, s_on, s_min;
  logic       s_off, s_hyst, s_rst, bo_clr, line_ov, skip, skip_fl;
  logic       gate, refr, hv, ss, t_en, t_dbl, frz, clamp, latched;
  logic [1:0] mode;
  logic [7:0] lfsr_r;
  cfs_state_e st, prev_st, exp_st, want_st;
  cfs_state_e exp_q[$];
  int         bad_count, checked, n, k, ss_cnt;

  always #20 ref_clk = ~ref_clk;

  cfs_supervisor #(.PERIOD_CYC(PER), .OVL_CYC(OVL), .REC_CYC(REC),
    .TEMP_BLANK_CYC(TBL), .BOOT_CYC(BOOT), .LATCH_VERSION(1'b0)) u_cfs_supervisor (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .OVERLOAD_FLAG(ovl),
    .CS_LIMIT_CMP(cs_lim), .CS_STOP_CMP(cs_stp), .CS_OPEN_CMP(cs_open),
    .FAULT_HI_CMP(f_hi), .FAULT_LO_CMP(f_lo), .SUPPLY_OV_CMP(s_ov),
    .SUPPLY_ON_CMP(s_on), .SUPPLY_MIN_CMP(s_min), .SUPPLY_OFF_CMP(s_off),
    .SUPPLY_HYST_CMP(s_hyst), .SUPPLY_RESET_CMP(s_rst), .BROWNOUT_CLEAR(bo_clr),
    .LINE_OV_CMP(line_ov), .SKIP_CMP(skip), .SKIP_FLOOR_CMP(skip_fl),
    .GATE_DRIVE_OUTPUT(gate), .REFRESH_SWITCH_OUTPUT(refr), .HV_SOURCE_EN(hv),
    .SOFT_START(ss), .TEMP_SRC_EN(t_en), .TEMP_SRC_DOUBLE(t_dbl),
    .SKIP_FREEZE(frz), .SKIP_FLOOR_CLAMP(clamp), .LATCHED_OFF(latched),
    .SUP_STATE(st));

  cfs_sense_model u_cfs_sense_model (
    .clk(ref_clk), .gate(gate), .mode(mode), .cs_limit(cs_lim), .cs_stop(cs_stp));

  // ==========================================
  // helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return gate;
      1: return t_en;
      2: return t_dbl;
      default: return st === want_st;
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
    #2;
  endtask

  // bounded wait for a watched bit to reach v, c counts edges taken
  task automatic wait_bit(input int w, input logic v, output int c);
    c = 0;
    while (pick(w) !== v && c < 2000) begin
      step(1);
      c++;
    end
    if (pick(w) !== v) begin
      $display("BAD wait %0d exp %0h seen %0h", w, v, pick(w));
      bad_count++;
      end_of_test();
    end
  endtask

  task automatic wait_st(input cfs_state_e s, output int c);
    want_st = s;
    wait_bit(3, 1'b1, c);
  endtask

  task automatic pulse();
    wait_bit(0, 1'b1, n);
    wait_bit(0, 1'b0, n);
  endtask

  // every state change must match the oldest noted expectation
  always @(posedge ref_clk) begin
    #1;
    if (ss === 1'b1) ss_cnt++;
    if (arst_n === 1'b1 && st !== prev_st) begin
      exp_st = exp_q.size() > 0 ? exp_q.pop_front() : prev_st;
      check("state", st, exp_st);
      prev_st = st;
    end
  end

  // ==========================================
  // scenarios
  initial begin
    {ovl, f_hi, f_lo, s_ov, s_on, s_min, s_off, s_rst, bo_clr, line_ov} = '0;
    {skip, skip_fl} = '0;
    {cs_open, s_hyst} = 2'h3;
    mode = 2'h0;
    lfsr_r = 8'h36;
    prev_st = CFS_IDLE;
    step(4);
    check("rst_hv", hv, 1);
    check("rst_st", st, CFS_IDLE);
    arst_n = 1'b1;
    step(4);
    check("temp_off", t_en, 0);
    s_min = 1'b1;
    wait_bit(1, 1'b1, n);
    check("dbl_on", t_dbl, 1);
    wait_bit(2, 1'b0, n);
    check("dbl_len", n, TBL);
    s_on = 1'b1;
    step(20);
    check("cs_open", st, CFS_IDLE);
    exp_q = '{CFS_BOOT, CFS_RUN};
    cs_open = 1'b0;
    wait_st(CFS_BOOT, n);
    check("boot_refr", refr, 1);
    wait_st(CFS_RUN, n);
    check("boot_len", n, BOOT);
    step(2);
    check("soft", ss_cnt, 1);
    pulse();
    step(2);
    check("off_refr", refr, 1);
    exp_q.push_back(CFS_RECOVER);
    mode = 2'h1;
    pulse();
    check("max_on", n, MAXON);
    wait_st(CFS_RECOVER, n);
    mode = 2'h0;
    exp_q = '{CFS_BOOT, CFS_RUN};
    wait_st(CFS_BOOT, n);
    check("rec_wait", n >= REC, 1);
    wait_st(CFS_RUN, n);
    repeat (2) begin
      ovl = 1'b1;
      step(40);
      ovl = 1'b0;
      step(5);
    end
    check("ovl_gap", st, CFS_RUN);
    exp_q.push_back(CFS_RECOVER);
    ovl = 1'b1;
    wait_st(CFS_RECOVER, n);
    check("ovl_time", n >= OVL, 1);
    ovl = 1'b0;
    exp_q = '{CFS_IDLE, CFS_BOOT, CFS_RUN};
    bo_clr = 1'b1;
    step(4);
    bo_clr = 1'b0;
    wait_st(CFS_RUN, n);
    // three surges, one clean pulse, three surges
    for (k = 0; k < 7; k++) begin
      mode = (k == 3) ? 2'h0 : 2'h2;
      pulse();
    end
    check("aoc_clear", st, CFS_RUN);
    exp_q.push_back(CFS_RECOVER);
    mode = 2'h2;
    pulse();
    wait_st(CFS_RECOVER, n);
    mode = 2'h0;
    exp_q = '{CFS_IDLE, CFS_BOOT, CFS_RUN};
    s_rst = 1'b1;
    step(4);
    s_rst = 1'b0;
    wait_st(CFS_RUN, n);
    lfsr_r = lfsr_next(lfsr_r);
    s_ov = 1'b1;
    step(20 + lfsr_r % 150);
    s_ov = 1'b0;
    step(10);
    check("ov_glitch", st, CFS_RUN);
    exp_q.push_back(CFS_RECOVER);
    s_ov = 1'b1;
    wait_st(CFS_RECOVER, n);
    check("ov_gate", gate, 0);
    s_ov = 1'b0;
    exp_q = '{CFS_BOOT, CFS_RUN};
    wait_st(CFS_RUN, n);
    // upper then lower fault level, released by line overvoltage then supply reset
    for (k = 0; k < 2; k++) begin
      lfsr_r = lfsr_next(lfsr_r);
      {f_hi, f_lo} = k ? 2'h1 : 2'h2;
      step(20 + lfsr_r % 150);
      {f_hi, f_lo} = 2'h0;
      step(PER * 6);
      check("flt_glitch", st, CFS_RUN);
      exp_q.push_back(CFS_LATCHED);
      {f_hi, f_lo} = k ? 2'h1 : 2'h2;
      wait_st(CFS_LATCHED, n);
      check("flt_time", n >= 250 + 3 * PER, 1);
      check("latch_gate", gate, 0);
      {f_hi, f_lo} = 2'h0;
      {s_off, s_hyst} = 2'h2;
      step(50);
      check("latch_hold", latched, 1);
      check("hiccup_on", hv, 1);
      {s_off, s_hyst} = 2'h1;
      step(4);
      check("hiccup_off", hv, 0);
      exp_q = '{CFS_IDLE, CFS_BOOT, CFS_RUN};
      {line_ov, s_rst} = k ? 2'h1 : 2'h2;
      step(4);
      {line_ov, s_rst} = 2'h0;
      wait_st(CFS_RUN, n);
    end
    pulse();
    skip = 1'b1;
    step(4);
    check("freeze", frz, 1);
    check("floor_off", clamp, 0);
    skip_fl = 1'b1;
    step(4);
    check("floor_on", clamp, 1);
    k = 0;
    repeat (2 * PER) begin
      step(1);
      k += (gate !== 1'b0);
    end
    check("skip_blank", k, 0);
    check("skip_refr", refr, 1);
    {skip, skip_fl} = 2'h0;
    step(PER * 2);
    check("exp_left", exp_q.size(), 0);
    end_of_test();
  end
endmodule

// ===== verilog/cfs_defs.svh
// timing figures, counts and limits of the converter fault supervisor
// assumes the logic clock is the 25 MHz switching reference
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH

// reference clock
`define CFS_CLK_NS          40
// cycles for a least time in ns, rounded up
`define CFS_CYC_UP(t)       (((t) + `CFS_CLK_NS - 1) / `CFS_CLK_NS)

// switching period and duty limit
`define CFS_PERIOD_CYC      250
`define CFS_MAX_DUTY_PCT    48
`define CFS_BLANK_NS        300
`define CFS_SHORT_BLANK_NS  100

// fault qualification
`define CFS_FLT_DGL_NS      10000
`define CFS_SUPOV_DGL_NS    20000
`define CFS_AOC_LIMIT       4
`define CFS_FPIN_LIMIT      4

// long timers
`define CFS_OVL_TIME_MS     15
`define CFS_OVL_CYC         (`CFS_OVL_TIME_MS * 1000000 / `CFS_CLK_NS)
`define CFS_REC_TIME_S      1
`define CFS_REC_CYC         (`CFS_REC_TIME_S * 1000000000 / `CFS_CLK_NS)
`define CFS_BOOT_NS         10000
`define CFS_TEMP_BLANK_US   1000
`define CFS_TEMP_BLANK_CYC  `CFS_CYC_UP(`CFS_TEMP_BLANK_US * 1000)

`endif

// ===== verilog/cfs_pkg.sv
// types shared by the converter fault supervisor
// assumes nothing beyond the defs header for numbers
package cfs_pkg;

  // supervisor sequence
  typedef enum logic [2:0] {
    CFS_IDLE,
    CFS_BOOT,
    CFS_RUN,
    CFS_RECOVER,
    CFS_LATCHED
  } cfs_state_e;

endpackage

// ===== verilog/cfs_qual_if.sv
// link between the supervisor and one comparator qualifier
// assumes raw comes straight from an analog comparator
`timescale 1ns/1ps

interface cfs_qual_if;
  logic raw;
  logic qual;

  modport filt (input raw, output qual);
  modport user (output raw, input qual);
endinterface

// ===== verilog/cfs_qualifier.sv
// comparator qualifier: two-stage synchroniser and minimum-high filter
// assumes raw is asynchronous to clk; qual is registered
`timescale 1ns/1ps

module cfs_qualifier #(
  parameter int MIN_CYC = 250
) (
  input  wire logic  clk,
  input  wire logic  arst_n,
  cfs_qual_if.filt   q
);
  import cfs_pkg::*;

  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_CYC - 1);

  if (MIN_CYC < 1) begin : g_chk
    $error("cfs_qualifier: MIN_CYC must be at least 1");
  end

  logic          s1_r;
  logic          s2_r;
  logic [CW-1:0] cnt_r;
  logic          qual_r;
  wire           held = s2_r && (cnt_r >= LAST);

  // ===========================================================
  // synchroniser and high-time filter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end else begin
      s1_r   <= q.raw;
      s2_r   <= s1_r;
      cnt_r  <= !s2_r ? '0 : (held ? cnt_r : cnt_r + 1'b1); // RULE11
      qual_r <= held; // RULE11
    end
  end

  assign q.qual = qual_r;

  // ===========================================================
  // checks
  short_reject_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
    !s2_r |=> !qual_r) else $error("qualifier passed a short pulse");

endmodule

// ===== verilog/cfs_supervisor.sv
// converter fault supervisor: drive sequencing and protection latching
// assumes REF_CLK is the switching reference, ARST_N the supply reset,
// and every comparator input arrives asynchronously
`timescale 1ns/1ps
`include "cfs_defs.svh"

// Behaviour
// RULE1: latched overload stops pulses, supply hiccups
// RULE2: latch released only by reset, brownout, line
// RULE3: second sense comparator, shorter blanking
// RULE4: four abnormal overcurrents in row trip
// RULE5: clean pulse clears abnormal overcurrent count
// RULE6: abnormal trip latches or recovers per option
// RULE7: qualified upper fault level latches off
// RULE8: qualified lower fault level latches off
// RULE9: temperature source off until supply minimum
// RULE10: blank lower comparator, double source current
// RULE11: fault comparators need ten microseconds high
// RULE12: fault seen four successive pulses latches
// RULE13: latched state drive off, endless hiccup
// RULE14: supply overvoltage twenty microseconds stops, recovers
// RULE15: open sense pin keeps start blocked; checked only on start from idle, not on restart after recovery
// RULE16: on-time ends at maximum duty
// RULE17: maximum duty pulses run overload timer
// RULE18: refresh switch on during boot interval
// RULE19: refresh switch on through off-time
// RULE20: refresh switch on in skip gaps
// RULE21: skip level freezes peak, blanks pulses
// RULE22: skip setpoint floor is reference quarter
// RULE23: overload must last past fault time
// RULE24: recovery waits one second timer
// RULE25: comparators pass two flip-flops first
// RULE26: overload timer clears when flag drops
module cfs_supervisor #(
  parameter int   PERIOD_CYC     = `CFS_PERIOD_CYC,
  parameter int   OVL_CYC        = `CFS_OVL_CYC,
  parameter int   REC_CYC        = `CFS_REC_CYC,
  parameter int   TEMP_BLANK_CYC = `CFS_TEMP_BLANK_CYC,
  parameter int   BOOT_CYC       = `CFS_CYC_UP(`CFS_BOOT_NS),
  parameter bit   LATCH_VERSION  = 1'b0
) (
  // clock and supply reset
  input  wire logic               REF_CLK,
  input  wire logic               ARST_N,
  // current sense and overload
  input  wire logic               OVERLOAD_FLAG,
  input  wire logic               CS_LIMIT_CMP,
  input  wire logic               CS_STOP_CMP,
  input  wire logic               CS_OPEN_CMP,
  // fault pin
  input  wire logic               FAULT_HI_CMP,
  input  wire logic               FAULT_LO_CMP,
  // supply levels
  input  wire logic               SUPPLY_OV_CMP,
  input  wire logic               SUPPLY_ON_CMP,
  input  wire logic               SUPPLY_MIN_CMP,
  input  wire logic               SUPPLY_OFF_CMP,
  input  wire logic               SUPPLY_HYST_CMP,
  input  wire logic               SUPPLY_RESET_CMP,
  // line supervision
  input  wire logic               BROWNOUT_CLEAR,
  input  wire logic               LINE_OV_CMP,
  // feedback
  input  wire logic               SKIP_CMP,
  input  wire logic               SKIP_FLOOR_CMP,
  // drive and supply control
  output logic                    GATE_DRIVE_OUTPUT,
  output logic                    REFRESH_SWITCH_OUTPUT,
  output logic                    HV_SOURCE_EN,
  output logic                    SOFT_START,
  // temperature source
  output logic                    TEMP_SRC_EN,
  output logic                    TEMP_SRC_DOUBLE,
  // skip control and status
  output logic                    SKIP_FREEZE,
  output logic                    SKIP_FLOOR_CLAMP,
  output logic                    LATCHED_OFF,
  output cfs_pkg::cfs_state_e     SUP_STATE
);
  import cfs_pkg::*;

  localparam int MAXON_CYC = PERIOD_CYC * `CFS_MAX_DUTY_PCT / 100;
  localparam int BLK_CYC   = `CFS_CYC_UP(`CFS_BLANK_NS);
  localparam int SBLK_CYC  = `CFS_CYC_UP(`CFS_SHORT_BLANK_NS);
  localparam int PW = $clog2(PERIOD_CYC);
  localparam int OW = $clog2(OVL_CYC + 1);
  localparam int RW = $clog2(REC_CYC + 1);
  localparam int TW = $clog2(TEMP_BLANK_CYC + 1);
  localparam int BW = $clog2(BOOT_CYC + 1);
  localparam logic [PW-1:0] PER_LAST = PW'(PERIOD_CYC - 1);
  localparam logic [PW-1:0] MAX_LAST = PW'(MAXON_CYC - 1);
  localparam logic [PW-1:0] BLK_END  = PW'(BLK_CYC);
  localparam logic [PW-1:0] SBLK_END = PW'(SBLK_CYC);
  localparam logic [OW-1:0] OVL_LAST = OW'(OVL_CYC - 1);
  localparam logic [RW-1:0] REC_LAST = RW'(REC_CYC - 1);
  localparam logic [TW-1:0] TMP_LAST = TW'(TEMP_BLANK_CYC);
  localparam logic [BW-1:0] BT_LAST  = BW'(BOOT_CYC - 1);
  localparam logic [2:0]    AOC_LAST = 3'(`CFS_AOC_LIMIT - 1);
  localparam logic [2:0]    FP_LAST  = 3'(`CFS_FPIN_LIMIT - 1);
  localparam int NS = 13;

  if (PERIOD_CYC < 16 || MAXON_CYC <= BLK_CYC || OVL_CYC < 2 || REC_CYC < 2
      || BOOT_CYC < 1 || TEMP_BLANK_CYC < 2) begin : g_chk
    $error("cfs_supervisor: timing parameters out of range");
  end

  // ===========================================================
  // input synchronisers
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  wire  [NS-1:0] raw = {SKIP_FLOOR_CMP, SKIP_CMP, LINE_OV_CMP, BROWNOUT_CLEAR,
                        SUPPLY_RESET_CMP, SUPPLY_HYST_CMP, SUPPLY_OFF_CMP,
                        SUPPLY_MIN_CMP, SUPPLY_ON_CMP, CS_OPEN_CMP, CS_STOP_CMP,
                        CS_LIMIT_CMP, OVERLOAD_FLAG};
  wire ov_s, lim_s, stop_s, open_s, on_s, min_s, off_s, hyst_s;
  wire rst_s, bo_s, lov_s, skip_s, floor_s;
  assign {floor_s, skip_s, lov_s, bo_s, rst_s, hyst_s, off_s, min_s, on_s,
          open_s, stop_s, lim_s, ov_s} = s2_r;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= raw; // RULE25
      s2_r <= s1_r; // RULE25
    end
  end

  // fault pin and supply overvoltage qualifiers
  function automatic int qual_cyc(input int ch);
    return (ch == 2) ? `CFS_CYC_UP(`CFS_SUPOV_DGL_NS) : `CFS_CYC_UP(`CFS_FLT_DGL_NS);
  endfunction

  cfs_qual_if fq[3] ();
  assign fq[0].raw = FAULT_HI_CMP;
  assign fq[1].raw = FAULT_LO_CMP;
  assign fq[2].raw = SUPPLY_OV_CMP;

  for (genvar i = 0; i < 3; i++) begin : g_qual
    cfs_qualifier #(.MIN_CYC(qual_cyc(i))) u_qual (
      .clk    (REF_CLK),
      .arst_n (ARST_N),
      .q      (fq[i])
    );
  end

  wire hi_q  = fq[0].qual;
  wire lo_q  = fq[1].qual;
  wire sov_q = fq[2].qual;

  // ===========================================================
  // state and counters
  cfs_state_e    st_r;
  cfs_state_e    st_nxt;
  logic [PW-1:0] per_r;
  logic [PW-1:0] on_r;
  logic          gate_r;
  logic          refresh_r;
  logic          hv_r;
  logic          ss_r;
  logic          maxdc_r;
  logic [OW-1:0] ovl_r;
  logic [RW-1:0] rec_r;
  logic [BW-1:0] boot_r;
  logic [2:0]    aoc_r;
  logic [2:0]    fp_r;
  logic          temp_en_r;
  logic [TW-1:0] temp_r;
  logic          dbl_r;
  logic          clamp_r;
  logic          latched_r;

  // ===========================================================
  // pulse decode
  wire in_run     = (st_r == CFS_RUN);
  wire pulse_go   = in_run && (per_r == '0) && !skip_s; // RULE21
  wire lim_end    = gate_r && lim_s && (on_r >= BLK_END);
  wire abn_trip   = gate_r && stop_s && (on_r >= SBLK_END); // RULE3
  wire max_end    = gate_r && (on_r == MAX_LAST); // RULE16
  wire pulse_end  = lim_end || abn_trip || max_end;
  wire pulse_done = in_run && pulse_end;
  wire aoc_trip   = pulse_done && abn_trip && (aoc_r == AOC_LAST); // RULE4
  wire temp_blank = temp_en_r && (temp_r != TMP_LAST);
  wire [TW-1:0] temp_step = temp_blank ? temp_r + 1'b1 : temp_r;
  wire fault_now  = hi_q || (lo_q && temp_en_r && !temp_blank); // RULE7 RULE8 RULE10
  wire fp_trip    = pulse_go && fault_now && (fp_r == FP_LAST); // RULE12
  wire ovl_cond   = in_run && (ov_s || maxdc_r); // RULE17
  wire ovl_exp    = ovl_cond && (ovl_r == OVL_LAST); // RULE23
  wire prot_trip  = aoc_trip || ovl_exp;
  wire go_latch   = fp_trip || (LATCH_VERSION && prot_trip); // RULE6
  wire go_rec     = sov_q || (!LATCH_VERSION && prot_trip); // RULE6 RULE14
  wire release_ev = rst_s || bo_s || lov_s; // RULE2
  wire rec_done   = (rec_r == REC_LAST);
  wire boot_done  = (boot_r == BT_LAST);
  wire drive_ok   = in_run && !go_latch && !go_rec;
  wire gate_nxt   = drive_ok && (pulse_go || (gate_r && !pulse_end)); // RULE13

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      CFS_IDLE:    if (on_s && !open_s) st_nxt = CFS_BOOT; // RULE15
      CFS_BOOT:    if (boot_done) st_nxt = CFS_RUN; // RULE18
      CFS_RUN: begin
        if (go_latch) st_nxt = CFS_LATCHED; // RULE1
        else if (go_rec) st_nxt = CFS_RECOVER; // RULE14
      end
      CFS_RECOVER: begin
        if (rst_s || bo_s) st_nxt = CFS_IDLE;
        else if (rec_done && on_s) st_nxt = CFS_BOOT; // RULE24
      end
      CFS_LATCHED: if (release_ev) st_nxt = CFS_IDLE; // RULE2
    endcase
  end

  // supply hiccup control of the startup source
  logic hv_nxt;
  always_comb begin
    hv_nxt = 1'b0;
    unique case (st_r)
      CFS_LATCHED: hv_nxt = off_s ? 1'b1 : (hyst_s ? 1'b0 : hv_r); // RULE1 RULE13
      CFS_IDLE,
      CFS_RECOVER: hv_nxt = !min_s ? 1'b1 : (on_s ? 1'b0 : hv_r);
      CFS_BOOT,
      CFS_RUN:     hv_nxt = 1'b0;
    endcase
  end

  // refresh switch: boot interval, then every off-time with a one-cycle gap
  wire refresh_boot = (st_nxt == CFS_BOOT); // RULE18
  wire refresh_off  = (st_nxt == CFS_RUN) && !gate_nxt && !gate_r; // RULE19 RULE20
  wire refresh_nxt  = refresh_boot || refresh_off;

  // ===========================================================
  // registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r      <= CFS_IDLE;
      per_r     <= '0;
      on_r      <= '0;
      gate_r    <= 1'b0;
      refresh_r <= 1'b0;
      hv_r      <= 1'b1;
      ss_r      <= 1'b0;
      maxdc_r   <= 1'b0;
      ovl_r     <= '0;
      rec_r     <= '0;
      boot_r    <= '0;
      aoc_r     <= '0;
      fp_r      <= '0;
      temp_en_r <= 1'b0;
      temp_r    <= '0;
      dbl_r     <= 1'b0;
      clamp_r   <= 1'b0;
      latched_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      per_r     <= (!in_run || per_r == PER_LAST) ? '0 : per_r + 1'b1;
      on_r      <= gate_nxt ? (gate_r ? on_r + 1'b1 : '0) : '0;
      gate_r    <= gate_nxt;
      refresh_r <= refresh_nxt;
      hv_r      <= hv_nxt;
      ss_r      <= (st_r == CFS_BOOT) && boot_done;
      if (in_run && max_end) maxdc_r <= 1'b1; // RULE17
      else if (!in_run || lim_end) maxdc_r <= 1'b0;
      ovl_r     <= (ovl_cond && !ovl_exp) ? ovl_r + 1'b1 : '0; // RULE26
      rec_r     <= (st_r != CFS_RECOVER) ? '0 : (rec_done ? rec_r : rec_r + 1'b1); // RULE24
      boot_r    <= (st_r != CFS_BOOT) ? '0 : boot_r + 1'b1;
      if (!in_run) aoc_r <= '0;
      else if (pulse_done) aoc_r <= abn_trip ? aoc_r + 1'b1 : '0; // RULE4 RULE5
      if (!in_run) fp_r <= '0;
      else if (pulse_go) fp_r <= fault_now ? fp_r + 1'b1 : '0; // RULE12
      temp_en_r <= temp_en_r || min_s; // RULE9
      temp_r    <= temp_step; // RULE10
      dbl_r     <= (temp_en_r || min_s) && (temp_step != TMP_LAST); // RULE10
      clamp_r   <= floor_s && skip_s; // RULE22
      latched_r <= (st_nxt == CFS_LATCHED); // RULE13
    end
  end

  // ===========================================================
  // outputs
  assign GATE_DRIVE_OUTPUT     = gate_r;
  assign REFRESH_SWITCH_OUTPUT = refresh_r;
  assign HV_SOURCE_EN          = hv_r;
  assign SOFT_START            = ss_r;
  assign TEMP_SRC_EN           = temp_en_r; // RULE9
  assign TEMP_SRC_DOUBLE       = dbl_r; // RULE10
  assign SKIP_FREEZE           = s2_r[11]; // RULE21
  assign SKIP_FLOOR_CLAMP      = clamp_r; // RULE22
  assign LATCHED_OFF           = latched_r;
  assign SUP_STATE             = st_r;

  // ===========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  duty_limit_a: assert property (gate_r |-> on_r <= MAX_LAST) // RULE16
    else $error("on-time passed the duty limit");
  latch_drive_a: assert property (st_r == CFS_LATCHED |-> !gate_r) // RULE13
    else $error("drive active while latched");
  latch_hold_a: assert property (st_r == CFS_LATCHED && !release_ev |=> LATCHED_OFF) // RULE2
    else $error("latch left without a release event");
  aoc_clear_a: assert property (pulse_done && !abn_trip |=> aoc_r == '0) // RULE5
    else $error("clean pulse did not clear the count");
  aoc_trip_a: assert property (aoc_trip |=> !gate_r && st_r != CFS_RUN) // RULE4
    else $error("fourth abnormal overcurrent did not stop drive");
  temp_double_a: assert property ($rose(temp_en_r) |-> TEMP_SRC_DOUBLE [*2]) // RULE10
    else $error("temperature source not doubled after enable");
  temp_off_a: assert property (!temp_en_r |-> !TEMP_SRC_EN && !TEMP_SRC_DOUBLE) // RULE9
    else $error("temperature source on before supply minimum");
  refresh_gap_a: assert property (gate_r |-> !refresh_r) // RULE19
    else $error("refresh switch overlaps drive");
  boot_refresh_a: assert property (st_r == CFS_BOOT |-> refresh_r && !gate_r) // RULE18
    else $error("refresh switch off during boot");
  skip_blank_a: assert property (in_run && skip_s |=> !$rose(gate_r)) // RULE21
    else $error("pulse started in skip");
  supov_stop_a: assert property (in_run && sov_q |=> st_r == CFS_RECOVER && !gate_r) // RULE14
    else $error("supply overvoltage did not stop drive");
  ovl_clear_a: assert property (in_run && !ov_s && !maxdc_r |=> ovl_r == '0) // RULE26
    else $error("overload timer kept counting");

  latch_seen_c: cover property (st_r == CFS_RUN ##1 st_r == CFS_LATCHED);
  recover_seen_c: cover property (st_r == CFS_RECOVER ##1 st_r == CFS_BOOT);
  skip_gap_c: cover property (in_run && skip_s && refresh_r);
  aoc_two_c: cover property (in_run && aoc_r == 3'h2);

endmodule
